// ===== hdl/ssie_params.svh
// Purpose: constants for the slot scan enumerator
// Assumes: included by the slot table, the enumerator and the bench
// Notes:   slot indices run A=0 .. N=13; card type codes are local choices
`ifndef SSIE_PARAMS_SVH
`define SSIE_PARAMS_SVH

`define SSIE_NUM_SLOTS      4'he
`define SSIE_LAST_SLOT      4'hd
`define SSIE_SLOT_A         4'h0
`define SSIE_SLOT_B         4'h1
`define SSIE_SLOT_C         4'h2
`define SSIE_SLOT_D         4'h3
`define SSIE_SLOT_E         4'h4
`define SSIE_SLOT_M         4'hc
`define SSIE_SLOT_N         4'hd

// card type codes reported by the plug-in cards
`define SSIE_TYPE_EMPTY     4'h0
`define SSIE_TYPE_CURRENT   4'h1
`define SSIE_TYPE_VOLTAGE   4'h2
`define SSIE_TYPE_IN8       4'h3
`define SSIE_TYPE_OUT5      4'h4
`define SSIE_TYPE_ARC       4'h5
`define SSIE_TYPE_COMM      4'h6

// base module resources and per-card channel counts
`define SSIE_BASE_INPUTS    8'h03
`define SSIE_BASE_OUTPUTS   8'h05
`define SSIE_BASE_PORTS     8'h02
`define SSIE_IN8_COUNT      8'h08
`define SSIE_OUT5_COUNT     8'h05
`define SSIE_ARC_SENSORS    8'h04
`define SSIE_ARC_FAST_OUTS  8'h02
`define SSIE_ARC_BIN_INS    8'h01
`define SSIE_COMM_COUNT     8'h01
`define SSIE_ONE            8'h01

// self-test wait, in cycles of the 20 MHz clock
`define SSIE_SELFTEST_NS    32'd1000
`define SSIE_CLK_NS         32'd50
`define SSIE_SELFTEST_CYC   8'(`SSIE_SELFTEST_NS / `SSIE_CLK_NS)

`endif

// ===== hdl/ssie_pkg.sv
// Purpose: types for the slot scan enumerator
// Assumes: nothing
// Notes:   constants live in ssie_params.svh
package ssie_pkg;
    // gray coded along idle, selftest, request, check, advance, done
    typedef enum logic [2:0] {
        SSIE_IDLE     = 3'h0,
        SSIE_SELFTEST = 3'h1,
        SSIE_REQUEST  = 3'h3,
        SSIE_CHECK    = 3'h2,
        SSIE_ADVANCE  = 3'h6,
        SSIE_DONE     = 3'h7
    } ssie_state_t;
endpackage

// ===== hdl/ssie_slot_table.sv
// Purpose: per-slot result memory for the enumerator
// Assumes: single writer, one read port
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ns
`include "ssie_params.svh"
module ssie_slot_table
    import ssie_pkg::*;
(
    input  wire logic        i_clk,     // system clock
    input  wire logic        i_rst,     // synchronous reset
    input  wire logic        i_wr,      // write strobe
    input  wire logic [3:0]  i_wr_addr, // slot written
    input  wire logic [15:0] i_wr_data, // {type, first channel, flags}
    input  wire logic [3:0]  i_rd_addr, // slot read
    output logic      [15:0] o_rd_data  // registered read data
);
    logic [15:0] mem_reg [0:`SSIE_LAST_SLOT];

    ////////////////////////////////////////////////////////////////////
    // write port; reset clears every entry so an unscanned slot reads zero
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < `SSIE_NUM_SLOTS; k++) begin
            if (i_rst) begin
                mem_reg[k] <= 16'h0000;
            end else if (i_wr && (i_wr_addr == 4'(k))) begin
                mem_reg[k] <= i_wr_data;
            end
        end
    end

    // registered read, out of range reads as zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= 16'h0000;
        end else if (i_rd_addr < `SSIE_NUM_SLOTS) begin
            o_rd_data <= mem_reg[i_rd_addr];
        end else begin
            o_rd_data <= 16'h0000;
        end
    end
endmodule

// ===== hdl/ssie_enumerator.sv
// Purpose: start-up slot scan and channel numbering for a modular relay
// Assumes: cards present their type codes on i_slot_type, sampled via two flops
// Notes:   scan runs once after reset; results per slot sit in the slot table
// Summary of operation
// - base module first, then slots A to N in ascending order, one at a time
// - first step self-tests base; inputs 1-3 and outputs 1-5 fixed
// - identify each card by type code; mismatch flags configuration error
// - slots A and B must be empty; occupied raises alarm
// - slots C and D must hold current-sense cards; missing raises alarm
// - slot E must hold voltage-sense card; missing raises alarm
// - empty option slot skipped with no channel numbers
// - first eight-input card gets inputs 4-11, first five-output gets 6-10
// - channels added only on type match; mismatch or missing card alarms
// - later cards of same type take the following block
// - arc card gets four light sensors, two fast outputs, one arc input
// - remaining slots repeat the same numbering after earlier slots
// - added comm ports numbered from 3; their settings are enabled
// - slots F to N take any add-on card; only M and N take comm cards
`timescale 1ns/1ns
`include "ssie_params.svh"
module ssie_enumerator
    import ssie_pkg::*;
(
    input  wire logic        i_clk,          // 20 MHz system clock
    input  wire logic        i_rst,          // synchronous reset, high
    input  wire logic [55:0] i_slot_type,    // 14 x 4-bit type codes, slot A low
    input  wire logic [13:0] i_slot_expect,  // slot expected to be fitted (F..N)
    input  wire logic        i_selftest_ok,  // base module self-test result
    input  wire logic [3:0]  i_rd_slot,      // slot result read address
    output logic      [15:0] o_rd_data,      // slot result {type, first ch, flags}
    output logic             o_scan_busy,    // scan in progress
    output logic             o_scan_done,    // scan finished, level
    output logic      [3:0]  o_slot,         // slot being scanned
    output logic             o_assign,       // pulse: channels given to o_slot
    output logic      [7:0]  o_first_input,  // first input channel of pulse
    output logic      [7:0]  o_first_output, // first output channel of pulse
    output logic      [7:0]  o_first_sensor, // first light sensor channel
    output logic      [7:0]  o_first_fast,   // first fast output channel
    output logic      [7:0]  o_arc_input,    // arc binary input channel
    output logic      [7:0]  o_comm_port,    // comm port number of pulse
    output logic      [7:0]  o_input_count,  // inputs numbered so far
    output logic      [7:0]  o_output_count, // outputs numbered so far
    output logic      [7:0]  o_port_count,   // comm ports numbered so far
    output logic      [13:0] o_port_enable,  // per-slot comm settings enabled
    output logic             o_base_fault,   // base self-test failed
    output logic             o_slot_alarm,   // sticky: any slot alarm
    output logic      [13:0] o_alarm_slots,  // per-slot alarm bits
    output logic             o_config_error  // sticky hardware config error
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers: card codes and straps come from other boards
    logic [55:0] type_s1_reg, type_s2_reg;
    logic [13:0] exp_s1_reg,  exp_s2_reg;
    logic        st_s1_reg,   st_s2_reg;

    always_ff @(posedge i_clk) begin
        type_s1_reg <= i_slot_type;
        type_s2_reg <= type_s1_reg;
        exp_s1_reg  <= i_slot_expect;
        exp_s2_reg  <= exp_s1_reg;
        st_s1_reg   <= i_selftest_ok;
        st_s2_reg   <= st_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // per-slot policy decoding, shared by the checker
    function automatic logic slot_must_be_empty(input logic [3:0] s);
        return (s == `SSIE_SLOT_A) || (s == `SSIE_SLOT_B);
    endfunction

    function automatic logic [3:0] fixed_type(input logic [3:0] s);
        if ((s == `SSIE_SLOT_C) || (s == `SSIE_SLOT_D)) begin
            return `SSIE_TYPE_CURRENT;
        end else if (s == `SSIE_SLOT_E) begin
            return `SSIE_TYPE_VOLTAGE;
        end
        return `SSIE_TYPE_EMPTY;
    endfunction

    // add-on slots take I/O and arc cards; comm only in M and N
    function automatic logic type_allowed(input logic [3:0] s, input logic [3:0] t);
        case (t)
            `SSIE_TYPE_IN8, `SSIE_TYPE_OUT5, `SSIE_TYPE_ARC: return 1'b1;
            `SSIE_TYPE_COMM: return (s == `SSIE_SLOT_M) || (s == `SSIE_SLOT_N);
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state and counters
    ssie_state_t state_reg, state_next;
    logic [3:0]  slot_reg;
    logic [7:0]  wait_reg;
    logic [7:0]  in_next_reg, out_next_reg, sens_next_reg, fast_next_reg, arc_next_reg, port_next_reg;

    // decode of the slot under scan
    wire  [3:0]  cur_type   = type_s2_reg[{slot_reg, 2'b00} +: 4];
    wire         cur_empty  = (cur_type == `SSIE_TYPE_EMPTY);
    wire         is_fixed   = (fixed_type(slot_reg) != `SSIE_TYPE_EMPTY);
    wire         is_addon   = !slot_must_be_empty(slot_reg) && !is_fixed;
    wire         bad_empty  = slot_must_be_empty(slot_reg) && !cur_empty;
    wire         bad_fixed  = is_fixed && (cur_type != fixed_type(slot_reg));
    wire         bad_addon  = is_addon && (cur_empty ? exp_s2_reg[slot_reg]
                                                     : !type_allowed(slot_reg, cur_type));
    wire         slot_bad   = bad_empty || bad_fixed || bad_addon;
    wire         give_chans = is_addon && !cur_empty && !slot_bad;
    wire         give_in    = give_chans && (cur_type == `SSIE_TYPE_IN8);
    wire         give_out   = give_chans && (cur_type == `SSIE_TYPE_OUT5);
    wire         give_arc   = give_chans && (cur_type == `SSIE_TYPE_ARC);
    wire         give_comm  = give_chans && (cur_type == `SSIE_TYPE_COMM);
    wire         last_slot  = (slot_reg == `SSIE_LAST_SLOT);
    wire  [7:0]  first_ch   = give_in   ? in_next_reg  :
                              give_out  ? out_next_reg :
                              give_arc  ? sens_next_reg :
                              give_comm ? port_next_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // next state: base first, then slots in order
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSIE_IDLE:     state_next = SSIE_SELFTEST;
            SSIE_SELFTEST: if (wait_reg == `SSIE_SELFTEST_CYC) state_next = SSIE_REQUEST;
            SSIE_REQUEST:  state_next = SSIE_CHECK;
            SSIE_CHECK:    state_next = SSIE_ADVANCE;
            SSIE_ADVANCE:  state_next = last_slot ? SSIE_DONE : SSIE_REQUEST;
            SSIE_DONE:     state_next = SSIE_DONE;
            default:       state_next = SSIE_IDLE;
        endcase
    end

    // sequencing and slot pointer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= SSIE_IDLE;
            slot_reg  <= `SSIE_SLOT_A;
            wait_reg  <= 8'h00;
        end else begin
            state_reg <= state_next;
            wait_reg  <= (state_reg == SSIE_SELFTEST) ? wait_reg + `SSIE_ONE : 8'h00;
            if (state_reg == SSIE_ADVANCE && !last_slot) begin
                slot_reg <= slot_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next-free counters, one per resource; base owns the lowest input, output and port numbers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            in_next_reg   <= `SSIE_BASE_INPUTS + `SSIE_ONE;
            out_next_reg  <= `SSIE_BASE_OUTPUTS + `SSIE_ONE;
            port_next_reg <= `SSIE_BASE_PORTS + `SSIE_ONE;
            sens_next_reg <= `SSIE_ONE;
            fast_next_reg <= `SSIE_ONE;
            arc_next_reg  <= `SSIE_ONE;
        end else if (state_reg == SSIE_CHECK) begin
            if (give_in)   in_next_reg   <= in_next_reg + `SSIE_IN8_COUNT;
            if (give_out)  out_next_reg  <= out_next_reg + `SSIE_OUT5_COUNT;
            if (give_comm) port_next_reg <= port_next_reg + `SSIE_COMM_COUNT;
            if (give_arc) begin
                sens_next_reg <= sens_next_reg + `SSIE_ARC_SENSORS;
                fast_next_reg <= fast_next_reg + `SSIE_ARC_FAST_OUTS;
                arc_next_reg  <= arc_next_reg + `SSIE_ARC_BIN_INS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assignment pulse and its channel numbers, registered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_assign       <= 1'b0;
            o_first_input  <= 8'h00;
            o_first_output <= 8'h00;
            o_first_sensor <= 8'h00;
            o_first_fast   <= 8'h00;
            o_arc_input    <= 8'h00;
            o_comm_port    <= 8'h00;
            o_port_enable  <= 14'h0000;
        end else begin
            o_assign       <= (state_reg == SSIE_CHECK) && give_chans;
            o_first_input  <= give_in   ? in_next_reg   : 8'h00;
            o_first_output <= give_out  ? out_next_reg  : 8'h00;
            o_first_sensor <= give_arc  ? sens_next_reg : 8'h00;
            o_first_fast   <= give_arc  ? fast_next_reg : 8'h00;
            o_arc_input    <= give_arc  ? arc_next_reg  : 8'h00;
            o_comm_port    <= give_comm ? port_next_reg : 8'h00;
            if ((state_reg == SSIE_CHECK) && give_comm) begin
                o_port_enable[slot_reg] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarms, sticky until reset; a rescan needs a reset anyway
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_alarm_slots  <= 14'h0000;
            o_slot_alarm   <= 1'b0;
            o_config_error <= 1'b0;
            o_base_fault   <= 1'b0;
        end else begin
            if ((state_reg == SSIE_CHECK) && slot_bad) begin
                o_alarm_slots[slot_reg] <= 1'b1;
                o_slot_alarm            <= 1'b1;
                o_config_error          <= 1'b1;
            end
            if ((state_reg == SSIE_SELFTEST) && (wait_reg == `SSIE_SELFTEST_CYC) && !st_s2_reg) begin
                o_base_fault   <= 1'b1;
                o_config_error <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result memory: one entry per slot
    ssie_slot_table u_table (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_wr      (state_reg == SSIE_CHECK),
        .i_wr_addr (slot_reg),
        .i_wr_data ({cur_type, first_ch, 2'b00, give_chans, slot_bad}),
        .i_rd_addr (i_rd_slot),
        .o_rd_data (o_rd_data)
    );

    assign o_scan_busy    = (state_reg != SSIE_DONE);
    assign o_scan_done    = (state_reg == SSIE_DONE);
    assign o_slot         = slot_reg;
    assign o_input_count  = in_next_reg - `SSIE_ONE;
    assign o_output_count = out_next_reg - `SSIE_ONE;
    assign o_port_count   = port_next_reg - `SSIE_ONE;

    ////////////////////////////////////////////////////////////////////
    // checks
    order_fwd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_ADVANCE && !last_slot) |=> (slot_reg == $past(slot_reg) + 4'h1))
        else $error("slot order broken");
    base_nums_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_SELFTEST) |-> (in_next_reg == 8'h04 && out_next_reg == 8'h06))
        else $error("base numbering wrong");
    empty_ab_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && slot_reg < 4'h2 && !cur_empty) |=> o_alarm_slots[$past(slot_reg)])
        else $error("occupied slot a/b not alarmed");
    fixed_cd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && (slot_reg == 4'h2 || slot_reg == 4'h3) && cur_type != 4'h1)
        |=> o_config_error)
        else $error("current card missing not flagged");
    skip_empty_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && cur_empty) |=> !o_assign && $stable(in_next_reg))
        else $error("empty slot numbered");
    in_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_in) |=> (in_next_reg == $past(in_next_reg) + 8'h08))
        else $error("input block step wrong");
    arc_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_arc) |=> (sens_next_reg == $past(sens_next_reg) + 8'h04)
        && (fast_next_reg == $past(fast_next_reg) + 8'h02))
        else $error("arc channels wrong");
    comm_slot_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && cur_type == 4'h6 && slot_reg < 4'hc) |-> !give_chans ##1 o_config_error)
        else $error("comm card accepted in wrong slot");

    // alarm side: a refused slot must be flagged and must not consume numbers
    cfg_err_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && slot_bad) |=> (o_config_error && o_slot_alarm))
        else $error("slot mismatch not flagged");
    volt_e_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && slot_reg == `SSIE_SLOT_E && cur_type != `SSIE_TYPE_VOLTAGE)
        |=> o_alarm_slots[`SSIE_SLOT_E])
        else $error("voltage card missing not alarmed");
    mismatch_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && slot_bad) |=> (!o_assign && $stable(out_next_reg) && $stable(port_next_reg)))
        else $error("refused card numbered");
    base_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_SELFTEST && wait_reg == `SSIE_SELFTEST_CYC && !st_s2_reg)
        |=> (o_base_fault && o_config_error))
        else $error("base self-test fault missed");

    // numbering side: blocks start where the running counters stand
    first_in_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_in && in_next_reg == 8'h04) |=> (o_assign && o_first_input == 8'h04))
        else $error("first input block wrong");
    first_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_out && out_next_reg == 8'h06) |=> (o_assign && o_first_output == 8'h06))
        else $error("first output block wrong");
    out_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_out) |=> (out_next_reg == $past(out_next_reg) + 8'h05))
        else $error("output block step wrong");
    arc_input_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_arc)
        |=> (o_arc_input == $past(arc_next_reg) && arc_next_reg == $past(arc_next_reg) + 8'h01))
        else $error("arc input channel wrong");
    port_num_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_CHECK && give_comm) |=> (o_port_enable[$past(slot_reg)] && o_comm_port >= 8'h03))
        else $error("comm port number or enable wrong");
    count_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg != SSIE_CHECK) |=> ($stable(in_next_reg) && $stable(out_next_reg) && $stable(port_next_reg)))
        else $error("counter moved outside slot check");

    // sequencing side: one pulse per slot, scan ends once and stays ended
    assign_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_assign |=> !o_assign)
        else $error("assign pulse too long");
    scan_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_ADVANCE && last_slot) |=> (o_scan_done && !o_scan_busy))
        else $error("scan did not end after last slot");
    done_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == SSIE_DONE) |=> (state_reg == SSIE_DONE && slot_reg == `SSIE_LAST_SLOT))
        else $error("scan restarted without reset");
endmodule

// ===== testbench/ssie_card_model.sv
// Purpose: plug-in card model presenting type codes for every slot
// Assumes: the bench loads the fitted card code of each slot
// Notes:   codes move only at the falling edge, like all bench stimulus
`timescale 1ns/1ns
module ssie_card_model (
    input  wire logic        i_clk,  // system clock
    input  wire logic [55:0] i_fit,  // fitted card codes, slot A low
    output logic      [55:0] o_type  // type codes seen by the enumerator
);
    ////////////////////////////////////////////////////////////////////////
    // a card reports a static level; an empty slot reads as the empty code
    initial o_type = 56'h0;
    always @(negedge i_clk) begin
        o_type <= i_fit;
    end
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for the slot scan enumerator
// Assumes: card codes held stable from reset until the scan is done
// Notes:   each scenario is a fresh reset and one full scan
`timescale 1ns/1ns
`include "ssie_params.svh"
module tb;
    import ssie_pkg::*;
    logic        i_clk, i_rst, i_selftest_ok, o_scan_busy, o_scan_done, o_assign;
    logic        o_base_fault, o_slot_alarm, o_config_error;
    logic [55:0] fit_bus, slot_type;
    logic [13:0] i_slot_expect, o_port_enable, o_alarm_slots, got_assign;
    logic [3:0]  i_rd_slot, o_slot, last_slot;
    logic [15:0] o_rd_data, rd;
    logic [7:0]  o_first_input, o_first_output, o_first_sensor, o_first_fast;
    logic [7:0]  o_arc_input, o_comm_port, o_input_count, o_output_count, o_port_count;
    logic [7:0]  cap_in [14];
    logic [7:0]  cap_out [14];
    logic [7:0]  cap_arc [14];
    logic [7:0]  cap_port [14];
    logic        order_bad;
    int          errors, n_tests;

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;

    ssie_card_model i_ssie_card_model (.i_clk(i_clk), .i_fit(fit_bus), .o_type(slot_type));

    ssie_enumerator i_ssie_enumerator (
        .i_clk(i_clk), .i_rst(i_rst), .i_slot_type(slot_type), .i_slot_expect(i_slot_expect),
        .i_selftest_ok(i_selftest_ok), .i_rd_slot(i_rd_slot), .o_rd_data(o_rd_data),
        .o_scan_busy(o_scan_busy), .o_scan_done(o_scan_done), .o_slot(o_slot), .o_assign(o_assign),
        .o_first_input(o_first_input), .o_first_output(o_first_output),
        .o_first_sensor(o_first_sensor), .o_first_fast(o_first_fast), .o_arc_input(o_arc_input),
        .o_comm_port(o_comm_port), .o_input_count(o_input_count), .o_output_count(o_output_count),
        .o_port_count(o_port_count), .o_port_enable(o_port_enable), .o_base_fault(o_base_fault),
        .o_slot_alarm(o_slot_alarm), .o_alarm_slots(o_alarm_slots), .o_config_error(o_config_error));

    ////////////////////////////////////////////////////////////////////////
    // capture every assign pulse; settled at the falling edge
    always @(negedge i_clk) begin
        if (o_assign === 1'b1) begin
            if (got_assign != 14'h0 && o_slot <= last_slot) order_bad = 1'b1;
            last_slot = o_slot;
            got_assign[o_slot] = 1'b1;
            cap_in[o_slot] = o_first_input;
            cap_out[o_slot] = o_first_output;
            cap_arc[o_slot] = (o_first_sensor == 8'h01 && o_first_fast == 8'h01) ? o_arc_input : 8'hff;
            cap_port[o_slot] = o_comm_port;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // reset with a new card set, then wait a bounded time for the scan end
    task automatic run_scan(input logic [55:0] fit, input logic [13:0] exp, input logic st);
        int n;
        fit_bus = fit;
        i_slot_expect = exp;
        i_selftest_ok = st;
        i_rst = 1'b1;
        got_assign = 14'h0;
        order_bad = 1'b0;
        repeat (4) @(negedge i_clk);
        check({o_scan_busy, o_assign, o_input_count, o_output_count[5:0]}, 16'h80c5);
        check({8'h0, o_port_count}, 16'h0002);
        i_rst = 1'b0;
        n = 0;
        while (o_scan_done !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        check({15'h0, o_scan_busy}, 16'h0000);
    endtask

    // slot result read: data appear one cycle after the address
    task automatic read_slot(input logic [3:0] s);
        i_rd_slot = s;
        @(negedge i_clk);
        @(negedge i_clk);
        rd = o_rd_data;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // fitted except K and L: two input cards, two output cards, arc, two comm cards
    task automatic test_full();
        run_scan(56'h66005443321100, 14'h33e0, 1'b1);
        check({15'h0, order_bad}, 16'h0000);
        check({8'h0, cap_in[5]}, 16'h0004);
        check({8'h0, cap_in[6]}, 16'h000c);
        check({8'h0, cap_out[7]}, 16'h0006);
        check({8'h0, cap_out[8]}, 16'h000b);
        check({8'h0, cap_arc[9]}, 16'h0001);
        check({cap_port[12], cap_port[13]}, 16'h0304);
        check({2'h0, o_port_enable}, 16'h3000);
        check({2'h0, got_assign & 14'h3fe0}, 16'h33e0);
        check({o_input_count, o_output_count}, 16'h130f);
        check({8'h0, o_port_count}, 16'h0004);
        check({2'h0, o_alarm_slots}, 16'h0000);
        check({13'h0, o_slot_alarm, o_config_error, o_base_fault}, 16'h0000);
        read_slot(4'h5);
        check(rd, {`SSIE_TYPE_IN8, 8'h04, 4'h2});
    endtask

    // every fault at once: forbidden, missing, wrong type, misplaced comm
    task automatic test_faults();
        run_scan(56'h60000506402043, 14'h21e0, 1'b0);
        check({2'h0, o_alarm_slots}, 16'h00df);
        check({13'h0, o_slot_alarm, o_config_error, o_base_fault}, 16'h0007);
        check({2'h0, got_assign & 14'h3fe0}, 16'h2120);
        check({8'h0, cap_out[5]}, 16'h0006);
        check({8'h0, cap_arc[8]}, 16'h0001);
        check({8'h0, cap_port[13]}, 16'h0003);
        check({2'h0, o_port_enable}, 16'h2000);
        check({o_input_count, o_output_count}, 16'h030a);
        check({8'h0, o_port_count}, 16'h0003);
        read_slot(4'h0);
        check({rd[15:12], 10'h0, rd[1:0]}, {`SSIE_TYPE_IN8, 12'h001});
    endtask

    // base only: all option slots empty and none expected
    task automatic test_empty();
        run_scan(56'h00000000021100, 14'h0000, 1'b1);
        check({2'h0, got_assign & 14'h3fe0}, 16'h0000);
        check({o_input_count, o_output_count}, 16'h0305);
        check({2'h0, o_alarm_slots}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence; every input has a value at time zero
    initial begin
        errors = 0;
        n_tests = 0;
        i_rst = 1'b1;
        fit_bus = 56'h0;
        i_slot_expect = 14'h0;
        i_selftest_ok = 1'b1;
        i_rd_slot = 4'h0;
        got_assign = 14'h0;
        order_bad = 1'b0;
        last_slot = 4'h0;
        @(negedge i_clk);
        test_full();
        test_faults();
        test_empty();
        stop_test();
    end

    // watchdog: three scans need well under 1000 cycles
    initial begin
        #100000;
        errors++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end
endmodule
